// ### iapfc_ctrl.sv
// Purpose: Flash in-application programming control registers and sequencer
// Assumes: APB slave on ref_clk; flash array takes start pulses and each operation ends after a fixed cycle count
// Notes: Registers, unlock timer and operation sequencer share one module
`timescale 1ns/100ps
`default_nettype none
module iapfc_ctrl #(
  parameter int PGM_CNT = iapfc_pkg::PGM_CYCLES,
  parameter int UNLOCK_CNT = iapfc_pkg::UNLOCK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpuHalt,
  output logic chipReset,
  output logic bufWrite,
  output logic [15:0] bufData,
  output logic [5:0] bufIndex,
  output logic bufClear,
  output logic flashErase,
  output logic flashProgram,
  output logic flashRead,
  output logic [13:0] flashAddr
);
  import iapfc_pkg::*;

  typedef enum logic [2:0] {IAPFC_IDLE, IAPFC_PGM, IAPFC_READ, IAPFC_CLR} iapfc_state_t;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic eraseWriteEnabled;
  logic [2:0] operationMode;
  logic unlockTrigger;
  logic programStart;
  logic readEnable;
  logic readStart;
  logic bufferClearStart;
  logic [7:0] chipResetPattern;
  logic [13:0] addr;
  logic [7:0] firstDataLow;
  logic [7:0] firstDataHigh;
  logic [7:0] unlockLow [1:3];
  logic [7:0] unlockHigh [1:3];
  logic [31:0] unlockTimer;
  logic [31:0] opTimer;
  iapfc_state_t state;

  logic wrEn;
  logic rdEn;
  logic [7:0] wb;
  logic patternOk;
  logic ctrlWr;
  logic opDone;

  // APB access strobes; the slave always answers in the access cycle
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign wb = pwdata[7:0];
  assign ctrlWr = wrEn && paddr == OFS_CTRL;
  assign patternOk = unlockLow[1] == KEY1L && unlockLow[2] == KEY2L && unlockLow[3] == KEY3L
    && unlockHigh[1] == KEY1H && unlockHigh[2] == KEY2H && unlockHigh[3] == KEY3H;
  assign opDone = opTimer == 32'h00000000;

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Zero wait states; unmapped reads give zero with no error
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // Read data latched in setup so it stands for the access cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rdEn) begin
      unique case (paddr)
        OFS_CTRL: prdata <= {24'h000000, eraseWriteEnabled, operationMode, unlockTrigger,
          programStart, readEnable, readStart};
        OFS_RSTPAT: prdata <= {24'h000000, chipResetPattern};
        OFS_BUFCLR: prdata <= {31'h00000000, bufferClearStart};
        OFS_ADDRL: prdata <= {24'h000000, addr[7:0]};
        OFS_ADDRH: prdata <= {26'h0000000, addr[13:8]};
        OFS_D0L: prdata <= {24'h000000, firstDataLow};
        OFS_D0H: prdata <= {24'h000000, firstDataHigh};
        OFS_D1L: prdata <= {24'h000000, unlockLow[1]};
        OFS_D1H: prdata <= {24'h000000, unlockHigh[1]};
        OFS_D2L: prdata <= {24'h000000, unlockLow[2]};
        OFS_D2H: prdata <= {24'h000000, unlockHigh[2]};
        OFS_D3L: prdata <= {24'h000000, unlockLow[3]};
        OFS_D3H: prdata <= {24'h000000, unlockHigh[3]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Data and unlock byte registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      firstDataLow <= RESET_BYTE;
      firstDataHigh <= RESET_BYTE;
      for (int i = 1; i <= 3; i++) begin
        unlockLow[i] <= RESET_BYTE;
        unlockHigh[i] <= RESET_BYTE;
      end
    end else if (wrEn) begin
      unique case (paddr)
        OFS_D0L: firstDataLow <= wb;
        OFS_D0H: firstDataHigh <= wb;
        OFS_D1L: unlockLow[1] <= wb;
        OFS_D1H: unlockHigh[1] <= wb;
        OFS_D2L: unlockLow[2] <= wb;
        OFS_D2H: unlockHigh[2] <= wb;
        OFS_D3L: unlockLow[3] <= wb;
        OFS_D3H: unlockHigh[3] <= wb;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Write buffer loading and address
  // ----------------------------------------
  // Buffer loads only once erase/write is enabled, so a locked part cannot stage data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr <= RESET_ADDR;
      bufWrite <= 1'b0;
      bufData <= 16'h0000;
      bufIndex <= 6'h00;
    end else begin
      bufWrite <= 1'b0;
      if (wrEn && paddr == OFS_ADDRL) begin
        addr[7:0] <= wb;
      end else if (wrEn && paddr == OFS_ADDRH) begin
        addr[13:8] <= wb[5:0];
      end else if (wrEn && paddr == OFS_D0H && eraseWriteEnabled) begin
        bufWrite <= 1'b1;
        bufData <= {wb, firstDataLow};
        bufIndex <= addr[5:0];
        if (addr[5:0] != PAGE_LAST) begin
          addr <= addr + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Unlock procedure
  // ----------------------------------------
  // Trigger arms only in unlock mode; the timer runs out regardless of pattern
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unlockTrigger <= 1'b0;
      unlockTimer <= 32'h00000000;
    end else if (ctrlWr && wb[BIT_UNLOCK] && !unlockTrigger && wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_UNLOCK) begin
      unlockTrigger <= 1'b1;
      unlockTimer <= 32'(UNLOCK_CNT);
    end else if (unlockTrigger) begin
      if (unlockTimer <= 32'h00000001) begin
        unlockTrigger <= 1'b0;
        unlockTimer <= 32'h00000000;
      end else begin
        unlockTimer <= unlockTimer - 32'h00000001;
      end
    end
  end

  // Enable flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eraseWriteEnabled <= 1'b0;
    end else if (unlockTrigger && patternOk && operationMode == MODE_UNLOCK) begin
      eraseWriteEnabled <= 1'b1;
    end else if (ctrlWr && !wb[BIT_EWEN]) begin
      eraseWriteEnabled <= 1'b0;
    end
  end

  // ----------------------------------------
  // Mode and read enable fields
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      operationMode <= MODE_WRITE;
      readEnable <= 1'b0;
      chipResetPattern <= RESET_BYTE;
    end else begin
      if (ctrlWr) begin
        operationMode <= wb[BIT_MODE_HI:BIT_MODE_LO];
        readEnable <= wb[BIT_RDEN];
      end
      if (wrEn && paddr == OFS_RSTPAT) begin
        chipResetPattern <= wb;
      end
    end
  end

  // Chip reset pulse on the key value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chipReset <= 1'b0;
    end else begin
      chipReset <= wrEn && paddr == OFS_RSTPAT && wb == CHIP_RESET_KEY;
    end
  end

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  // Start bits only take when the operation may legally run, else they read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= IAPFC_IDLE;
      programStart <= 1'b0;
      readStart <= 1'b0;
      bufferClearStart <= 1'b0;
      opTimer <= 32'h00000000;
      flashErase <= 1'b0;
      flashProgram <= 1'b0;
      flashRead <= 1'b0;
      bufClear <= 1'b0;
      cpuHalt <= 1'b0;
      flashAddr <= RESET_ADDR;
    end else begin
      flashErase <= 1'b0;
      flashProgram <= 1'b0;
      flashRead <= 1'b0;
      bufClear <= 1'b0;
      unique case (state)
        IAPFC_IDLE: begin
          if (ctrlWr && wb[BIT_PGM] && eraseWriteEnabled
              && (wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_WRITE || wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_ERASE)) begin
            programStart <= 1'b1;
            flashErase <= wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_ERASE;
            flashProgram <= wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_WRITE;
            flashAddr <= addr;
            opTimer <= 32'(PGM_CNT);
            cpuHalt <= 1'b1;
            state <= IAPFC_PGM;
          end else if (ctrlWr && wb[BIT_RDGO] && readEnable && wb[BIT_RDEN]
                       && wb[BIT_MODE_HI:BIT_MODE_LO] == MODE_READ) begin
            readStart <= 1'b1;
            flashRead <= 1'b1;
            flashAddr <= addr;
            opTimer <= 32'(READ_CYCLES);
            cpuHalt <= 1'b1;
            state <= IAPFC_READ;
          end else if (wrEn && paddr == OFS_BUFCLR && wb[0]) begin
            bufferClearStart <= 1'b1;
            bufClear <= 1'b1;
            opTimer <= 32'(BUFCLR_CYCLES);
            state <= IAPFC_CLR;
          end
        end
        IAPFC_PGM: begin
          if (opDone) begin
            programStart <= 1'b0;
            bufClear <= 1'b1;
            cpuHalt <= 1'b0;
            state <= IAPFC_IDLE;
          end else begin
            opTimer <= opTimer - 32'h00000001;
          end
        end
        IAPFC_READ: begin
          if (opDone) begin
            readStart <= 1'b0;
            cpuHalt <= 1'b0;
            state <= IAPFC_IDLE;
          end else begin
            opTimer <= opTimer - 32'h00000001;
          end
        end
        IAPFC_CLR: begin
          if (opDone) begin
            bufferClearStart <= 1'b0;
            state <= IAPFC_IDLE;
          end else begin
            opTimer <= opTimer - 32'h00000001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_badUnlock;
    unlockTrigger && !patternOk;
  endsequence

  property p_flagNoSwSet;
    @(posedge ref_clk) disable iff (!rst_n)
      (!eraseWriteEnabled && !(unlockTrigger && patternOk)) |=> !eraseWriteEnabled;
  endproperty
  a_flagNoSwSet: assert property (p_flagNoSwSet) else $error("enable flag set without unlock");
  property p_flagClear;
    @(posedge ref_clk) disable iff (!rst_n)
      (ctrlWr && !wb[BIT_EWEN] && !unlockTrigger) |=> !eraseWriteEnabled;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("enable flag not cleared");
  property p_unlockSet;
    @(posedge ref_clk) disable iff (!rst_n)
      (unlockTrigger && patternOk && operationMode == MODE_UNLOCK) |=> eraseWriteEnabled;
  endproperty
  a_unlockSet: assert property (p_unlockSet) else $error("unlock did not enable");
  property p_badKeepsLow;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_badUnlock ##0 !eraseWriteEnabled) |=> !eraseWriteEnabled || patternOk;
  endproperty
  a_badKeepsLow: assert property (p_badKeepsLow) else $error("bad pattern enabled flash");
  property p_noLockedPgm;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(programStart) |-> $past(eraseWriteEnabled);
  endproperty
  a_noLockedPgm: assert property (p_noLockedPgm) else $error("program started while locked");
  property p_haltPgm;
    @(posedge ref_clk) disable iff (!rst_n)
      (programStart || readStart) |-> cpuHalt;
  endproperty
  a_haltPgm: assert property (p_haltPgm) else $error("cpu not halted during operation");
  property p_readGate;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(readStart) |-> $past(readEnable) && flashRead;
  endproperty
  a_readGate: assert property (p_readGate) else $error("read without enable");
  property p_readDone;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(readStart) |-> ##[1:8] !readStart;
  endproperty
  a_readDone: assert property (p_readDone) else $error("read start not cleared");
  property p_chipReset;
    @(posedge ref_clk) disable iff (!rst_n)
      (wrEn && paddr == OFS_RSTPAT && wb == CHIP_RESET_KEY) |=> chipReset;
  endproperty
  a_chipReset: assert property (p_chipReset) else $error("no chip reset on key");
  property p_bufClrDone;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(bufferClearStart) |-> ##[1:4] !bufferClearStart;
  endproperty
  a_bufClrDone: assert property (p_bufClrDone) else $error("buffer clear stuck");

  property p_pageHold;
    @(posedge ref_clk) disable iff (!rst_n)
      (bufWrite && bufIndex == PAGE_LAST) |-> addr[5:0] == PAGE_LAST;
  endproperty
  a_pageHold: assert property (p_pageHold) else $error("address left page");

  property p_unlockTimeout;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(unlockTrigger) |-> unlockTimer != 32'h00000000;
  endproperty
  a_unlockTimeout: assert property (p_unlockTimeout) else $error("unlock timer not loaded");

endmodule
`default_nettype wire

// ### iapfc_pkg.sv
// Purpose: Constants for the in-application flash programming control block
// Assumes: APB slave, 32-bit data, 8-bit registers in the low byte lanes
// Notes: Offsets are byte addresses of one aligned word per register
package iapfc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RSTPAT = 8'h04;
  localparam logic [7:0] OFS_BUFCLR = 8'h08;
  localparam logic [7:0] OFS_ADDRL = 8'h0C;
  localparam logic [7:0] OFS_ADDRH = 8'h10;
  localparam logic [7:0] OFS_D0L = 8'h14;
  localparam logic [7:0] OFS_D0H = 8'h18;
  localparam logic [7:0] OFS_D1L = 8'h1C;
  localparam logic [7:0] OFS_D1H = 8'h20;
  localparam logic [7:0] OFS_D2L = 8'h24;
  localparam logic [7:0] OFS_D2H = 8'h28;
  localparam logic [7:0] OFS_D3L = 8'h2C;
  localparam logic [7:0] OFS_D3H = 8'h30;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int BIT_EWEN = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_UNLOCK = 3;
  localparam int BIT_PGM = 2;
  localparam int BIT_RDEN = 1;
  localparam int BIT_RDGO = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [13:0] RESET_ADDR = 14'h0000;
  // ----------------------------------------
  // Mode codes and patterns
  // ----------------------------------------
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam logic [7:0] KEY1L = 8'h00;
  localparam logic [7:0] KEY2L = 8'h0D;
  localparam logic [7:0] KEY3L = 8'hC3;
  localparam logic [7:0] KEY1H = 8'h04;
  localparam logic [7:0] KEY2H = 8'h09;
  localparam logic [7:0] KEY3H = 8'h40;
  localparam logic [5:0] PAGE_LAST = 6'h3F;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int PGM_TIME_US = 2200;
  localparam int PGM_CYCLES = (CLK_HZ / 1000000) * PGM_TIME_US;
  localparam int UNLOCK_TIME_US = 100;
  localparam int UNLOCK_CYCLES = (CLK_HZ / 1000000) * UNLOCK_TIME_US;
  localparam int READ_CYCLES = 4;
  localparam int BUFCLR_CYCLES = 2;
endpackage

// ### iap_flash_control_regs_tb_top.sv
// Purpose: Self-checking bench for the flash programming control registers
// Assumes: APB answers with registered pready; short counts set for simulation
// Notes: Reset value reads and table rows first, then hand-written sequences for unlock and operations
`timescale 1ns/100ps
`default_nettype none
module iap_flash_control_regs_tb_top;
  import iapfc_pkg::*;
  localparam int PGM_SIM = 20;
  localparam int UNLOCK_SIM = 50;
  localparam int TIMEOUT = 5000;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} iapfc_row_t;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, cpuHalt, chipReset;
  logic bufWrite, bufClear, flashErase, flashProgram, flashRead;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] bufData, lastData;
  logic [5:0] bufIndex, lastIdx;
  logic [13:0] flashAddr;
  int errorCnt, checked, cycles, pgmCnt, ersCnt, rdCnt, bwCnt, bcCnt, crCnt, haltCnt;
  iapfc_row_t rows[16];
  // ----------------------------------------
  // Design and clock
  // ----------------------------------------
  iapfc_ctrl #(.PGM_CNT(PGM_SIM), .UNLOCK_CNT(UNLOCK_SIM)) iapfc_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuHalt(cpuHalt), .chipReset(chipReset), .bufWrite(bufWrite), .bufData(bufData),
    .bufIndex(bufIndex), .bufClear(bufClear), .flashErase(flashErase),
    .flashProgram(flashProgram), .flashRead(flashRead), .flashAddr(flashAddr));
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Pulse counters, sampled mid-cycle so a check right after an edge never races them
  always @(negedge ref_clk) begin
    if (rst_n === 1'b1) begin
      pgmCnt += (flashProgram === 1'b1);
      ersCnt += (flashErase === 1'b1);
      rdCnt += (flashRead === 1'b1);
      bcCnt += (bufClear === 1'b1);
      crCnt += (chipReset === 1'b1);
      haltCnt += (cpuHalt === 1'b1);
      if (bufWrite === 1'b1) begin
        bwCnt++;
        lastData = bufData;
        lastIdx = bufIndex;
      end
    end
  end
  // Hang guard: a stuck handshake ends in the same report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      errorCnt++;
      $display("[FAIL] timeout exp done seen stuck");
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask
  // Start an operation and wait for the halt to drop
  task automatic runOp(input logic [7:0] c);
    haltCnt = 0;
    wr(OFS_CTRL, c);
    repeat (2) @(posedge ref_clk);
    #1 chk("cpuHalt raised", cpuHalt, 1);
    @(posedge ref_clk);
    for (int i = 0; i < 300 && cpuHalt !== 1'b0; i++) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; rst_n = 0;
    rows = '{'{OFS_D1L, 32'hA5, 32'hA5}, '{OFS_D1H, 32'h5A, 32'h5A}, '{OFS_D2L, 32'hFF, 32'hFF},
      '{OFS_D2H, 32'h01, 32'h01}, '{OFS_D3L, 32'h80, 32'h80}, '{OFS_D3H, 32'h7E, 32'h7E},
      '{OFS_RSTPAT, 32'h12, 32'h12}, '{OFS_BUFCLR, 32'hFE, 32'h00}, '{8'h3C, 32'hFF, 32'h00},
      '{OFS_CTRL, 32'h80, 32'h00}, '{OFS_CTRL, 32'h10, 32'h10}, '{OFS_CTRL, 32'h30, 32'h30},
      '{OFS_CTRL, 32'h60, 32'h60}, '{OFS_CTRL, 32'h00, 32'h00}, '{OFS_ADDRH, 32'hFF, 32'h3F},
      '{OFS_ADDRL, 32'hC3, 32'hC3}};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a <= 8'h30; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, r);
      chk("reset value", r, 32'h0);
    end
    $display("test reset values done");
    // Table: write, read back, compare with the expected image
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d[7:0]);
      apb(1'b0, rows[i].a, 32'h0, r);
      chk("register readback", r, rows[i].e);
    end
    chk("slave error", pslverr, 0);
    $display("test register table done");
    // Locked: a program request must be refused
    wr(OFS_CTRL, 8'h04);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("locked ctrl", r, 32'h00);
    chk("locked program pulses", pgmCnt, 0);
    // Wrong pattern: timer runs out, trigger clears, flag stays low
    wr(OFS_CTRL, 8'h68);
    repeat (UNLOCK_SIM + 10) @(posedge ref_clk);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("bad unlock ctrl", r, 32'h60);
    // Correct pattern inside the timer window
    wr(OFS_CTRL, 8'h68);
    wr(OFS_D1L, KEY1L);
    wr(OFS_D2L, KEY2L);
    wr(OFS_D3L, KEY3L);
    wr(OFS_D1H, KEY1H);
    wr(OFS_D2H, KEY2H);
    wr(OFS_D3H, KEY3H);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("unlocked ctrl", r, 32'hE8);
    repeat (UNLOCK_SIM + 10) @(posedge ref_clk);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("trigger timeout", r, 32'hE0);
    $display("test unlock done");
    // Buffer loads near the page end: address must stick at the last word
    wr(OFS_CTRL, 8'h80);
    wr(OFS_ADDRL, 8'h3E);
    wr(OFS_ADDRH, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_D0L, 8'h34);
      wr(OFS_D0H, 8'(8'h12 + i));
      chk("buffer data", lastData, {8'(8'h12 + i), 8'h34});
      chk("buffer index", lastIdx, (i == 0) ? 6'h3E : PAGE_LAST);
      apb(1'b0, OFS_ADDRL, 32'h0, r);
      chk("address low", r, 32'h3F);
    end
    chk("buffer writes", bwCnt, 3);
    $display("test buffer load done");
    // Erase, then write: busy spans the programming time
    runOp(8'h94);
    chk("erase pulses", ersCnt, 1);
    chk("erase address", flashAddr, 32'h3F);
    chk("halt length", (haltCnt >= PGM_SIM) && (haltCnt <= PGM_SIM + 2), 1);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("erase done ctrl", r, 32'h90);
    runOp(8'h84);
    chk("program pulses", pgmCnt, 1);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("write done ctrl", r, 32'h80);
    $display("test erase and write done");
    // Read: enable first, start in a second write
    wr(OFS_CTRL, 8'hB2);
    runOp(8'hB3);
    chk("read pulses", rdCnt, 1);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("read done ctrl", r, 32'hB2);
    wr(OFS_CTRL, 8'hB1);
    repeat (8) @(posedge ref_clk);
    chk("read while disabled", rdCnt, 1);
    $display("test read done");
    // Buffer clear self-clears; two earlier ends also pulsed clear
    wr(OFS_BUFCLR, 8'h01);
    repeat (6) @(posedge ref_clk);
    apb(1'b0, OFS_BUFCLR, 32'h0, r);
    chk("buffer clear bit", r, 32'h00);
    chk("buffer clear pulses", bcCnt, 3);
    // Software clear of the flag locks erase again
    wr(OFS_CTRL, 8'h10);
    wr(OFS_CTRL, 8'h14);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFS_CTRL, 32'h0, r);
    chk("relocked ctrl", r, 32'h10);
    chk("relocked erase", ersCnt, 1);
    $display("test relock done");
    // Only the exact pattern resets the chip
    wr(OFS_RSTPAT, 8'h54);
    chk("near key reset", crCnt, 0);
    wr(OFS_RSTPAT, CHIP_RESET_KEY);
    repeat (2) @(posedge ref_clk);
    chk("chip reset pulses", crCnt, 1);
    $display("test chip reset done");
    results();
  end
endmodule
`default_nettype wire
